// ===== pkg/lle_pkg.sv
// constants, codes and types for the link error log encoder
package lle_pkg;

  // ----------------------------------------------------------------
  // error codes of the transmission-failure group
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_DEST_BUSY = 16'h0109;
  localparam logic [15:0] CODE_CTRL_FAULT = 16'h010A;
  localparam logic [15:0] CODE_HOST_ERR = 16'h010B;
  localparam logic [15:0] CODE_UNIT_NUM = 16'h010C;
  localparam logic [15:0] CODE_DEST_ADDR = 16'h010D;
  localparam logic [15:0] CODE_NO_ROUTE = 16'h010E;
  localparam logic [15:0] CODE_ROUTE_BAD = 16'h010F;
  localparam logic [15:0] CODE_RELAY_MAX = 16'h0110;
  localparam logic [15:0] CODE_PKT_LONG = 16'h0111;
  localparam logic [15:0] CODE_HDR_BAD = 16'h0112;
  localparam logic [15:0] CODE_IO_CFG = 16'h0113;
  localparam logic [15:0] CODE_BUS_ERR = 16'h0114;
  localparam logic [15:0] CODE_IO_OVERLAP = 16'h0115;
  localparam logic [15:0] CODE_UNIT_ERR = 16'h0116;

  // ----------------------------------------------------------------
  // detail word layout
  // ----------------------------------------------------------------
  localparam int DET_NODE_LSB = 0;
  localparam int DET_NODE_W = 8;
  localparam int DET_NET_LSB = 8;
  localparam int DET_NET_W = 7;
  localparam int DET_BLK_BIT = 15;
  localparam int BYTE_HI_LSB = 8;
  localparam int BYTE_LO_LSB = 0;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int LOG_DEPTH_DEF = 16;
  localparam int HIT_W_DEF = 8;
  localparam int NUM_CAUSES = 14;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // failure causes reported by the transmit path
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CS_DEST_BUSY = 4'h0,
    CS_CTRL_FAULT = 4'h1,
    CS_HOST_ERR = 4'h2,
    CS_UNIT_NUM = 4'h3,
    CS_DEST_ADDR = 4'h4,
    CS_NO_ROUTE = 4'h5,
    CS_ROUTE_BAD = 4'h6,
    CS_RELAY_MAX = 4'h7,
    CS_PKT_LONG = 4'h8,
    CS_HDR_BAD = 4'h9,
    CS_IO_CFG = 4'hA,
    CS_BUS_ERR = 4'hB,
    CS_IO_OVERLAP = 4'hC,
    CS_UNIT_ERR = 4'hD
  } lle_cause_e;

  // nonvolatile handshake, gray along idle -> req -> done
  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_REQ = 2'b01,
    NV_DONE = 2'b11
  } lle_nv_e;

endpackage

// ===== rtl/lle_link_error_log_encoder.sv
// link error log encoder: failure causes to code and detail entries
`timescale 1ns/1ns
// Function
// RULE1: destination busy logs 0109, not kept in nonvolatile memory.
// RULE2: controller fault logs 010A and is the only code also written nonvolatile.
// RULE3: host controller in error logs 010B, volatile only.
// RULE4: unit number out of range or duplicated logs 010C, volatile only.
// RULE5: invalid destination address aborts sending and logs 010D.
// RULE6: routing needed without routing tables aborts sending and logs 010E.
// RULE7: inconsistent routing tables abort sending and log 010F.
// RULE8: too many relay networks aborts sending and logs 0110.
// RULE9: overlong command packet is rejected and logs 0111.
// RULE10: malformed command header is rejected and logs 0112.
// RULE11: I/O configuration fault logs 0113, volatile only.
// RULE12: internal backplane bus fault logs 0114, volatile only.
// RULE13: overlapping unit I/O allocations log 0115, volatile only.
// RULE14: backplane unit fault logs 0116, volatile only.
// RULE15: detail holds node bits 0-7, network 8-14, bit 15 set for response.
// RULE16: detail byte one is bits 8-15, byte two is bits 0-7.
// RULE17: entries are code then detail, appended in order, host readable.
module lle_link_error_log_encoder
  import lle_pkg::*;
#(
  parameter int LOG_DEPTH = LOG_DEPTH_DEF,
  parameter int HIT_W = HIT_W_DEF,
  parameter int AW = $clog2(LOG_DEPTH)
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // failure report from the transmit path
  input wire logic fail_valid,
  input wire logic [3:0] fail_cause,
  input wire logic fail_is_resp,
  input wire logic [7:0] fail_node,
  input wire logic [6:0] fail_net,
  // verdict back to the transmit path
  output logic tx_abort,
  output logic pkt_reject,
  output logic bad_cause,
  // log readout by the host controller
  input wire logic log_clear,
  input wire logic rd_req,
  input wire logic [AW-1:0] rd_idx,
  output logic rd_valid,
  output logic rd_miss,
  output logic [15:0] rd_code,
  output logic [15:0] rd_detail,
  output logic [7:0] rd_byte_hi,
  output logic [7:0] rd_byte_lo,
  output logic [AW:0] log_count,
  output logic log_full,
  output logic log_overflow,
  // most recent entry
  output logic new_entry,
  output logic [15:0] last_code,
  output logic [15:0] last_detail,
  // per-cause hit counters
  input wire logic [3:0] hit_sel,
  output logic [HIT_W-1:0] hit_value,
  // nonvolatile store handshake
  output logic nv_req,
  output logic [15:0] nv_code,
  output logic [15:0] nv_detail,
  input wire logic nv_ack,
  output logic nv_busy,
  output logic nv_lost
);

  // ----------------------------------------------------------------
  // cause decode
  // ----------------------------------------------------------------
  logic [15:0] code_c;
  logic known_c;
  logic to_nv_c;
  logic abort_c;
  logic reject_c;
  logic [15:0] detail_c;
  logic ev_c;

  always_comb begin
    code_c = RST_WORD;
    known_c = 1'b1;
    to_nv_c = 1'b0;
    abort_c = 1'b0;
    reject_c = 1'b0;
    case (fail_cause)
      CS_DEST_BUSY: code_c = CODE_DEST_BUSY; // see RULE1
      CS_CTRL_FAULT: begin
        code_c = CODE_CTRL_FAULT; // see RULE2
        to_nv_c = 1'b1; // see RULE2
      end
      CS_HOST_ERR: code_c = CODE_HOST_ERR; // see RULE3
      CS_UNIT_NUM: code_c = CODE_UNIT_NUM; // see RULE4
      CS_DEST_ADDR: begin
        code_c = CODE_DEST_ADDR; // see RULE5
        abort_c = 1'b1; // see RULE5
      end
      CS_NO_ROUTE: begin
        code_c = CODE_NO_ROUTE; // see RULE6
        abort_c = 1'b1; // see RULE6
      end
      CS_ROUTE_BAD: begin
        code_c = CODE_ROUTE_BAD; // see RULE7
        abort_c = 1'b1; // see RULE7
      end
      CS_RELAY_MAX: begin
        code_c = CODE_RELAY_MAX; // see RULE8
        abort_c = 1'b1; // see RULE8
      end
      CS_PKT_LONG: begin
        code_c = CODE_PKT_LONG; // see RULE9
        reject_c = 1'b1; // see RULE9
      end
      CS_HDR_BAD: begin
        code_c = CODE_HDR_BAD; // see RULE10
        reject_c = 1'b1; // see RULE10
      end
      CS_IO_CFG: code_c = CODE_IO_CFG; // see RULE11
      CS_BUS_ERR: code_c = CODE_BUS_ERR; // see RULE12
      CS_IO_OVERLAP: code_c = CODE_IO_OVERLAP; // see RULE13
      CS_UNIT_ERR: code_c = CODE_UNIT_ERR; // see RULE14
      // codes 14 and 15 name no cause and are never logged
      default: known_c = 1'b0;
    endcase
  end

  always_comb begin
    detail_c = RST_WORD;
    detail_c[DET_NODE_LSB +: DET_NODE_W] = fail_node; // see RULE15
    detail_c[DET_NET_LSB +: DET_NET_W] = fail_net; // see RULE15
    detail_c[DET_BLK_BIT] = fail_is_resp; // see RULE15
  end

  assign ev_c = fail_valid && known_c;

  // ----------------------------------------------------------------
  // verdict pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_abort <= 1'b0;
      pkt_reject <= 1'b0;
      bad_cause <= 1'b0;
    end else if (ce) begin
      tx_abort <= ev_c && abort_c; // see RULE5
      pkt_reject <= ev_c && reject_c; // see RULE9
      bad_cause <= fail_valid && !known_c;
    end
  end

  // ----------------------------------------------------------------
  // log store
  // ----------------------------------------------------------------
  // a full log keeps its oldest entries; new ones are dropped and flagged,
  // so the first failure of a burst, usually the root cause, survives
  logic [15:0] code_mem [LOG_DEPTH];
  logic [15:0] det_mem [LOG_DEPTH];
  logic [AW:0] count_q;
  logic full_c;
  logic wr_c;
  logic [AW-1:0] wr_idx_c;

  assign full_c = (count_q == (AW+1)'(LOG_DEPTH));
  assign wr_c = ev_c && (log_clear || !full_c);
  assign wr_idx_c = log_clear ? '0 : count_q[AW-1:0];

  always_ff @(posedge clk_sys) begin
    if (ce && wr_c) begin
      code_mem[wr_idx_c] <= code_c; // see RULE17
      det_mem[wr_idx_c] <= detail_c; // see RULE17
    end
  end

  // an entry arriving with the clear survives as the first of the new log
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (ce) begin
      if (log_clear) begin
        count_q <= ev_c ? (AW+1)'(1) : '0;
      end else if (wr_c) begin
        count_q <= count_q + (AW+1)'(1); // see RULE17
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      log_overflow <= 1'b0;
    end else if (ce) begin
      if (ev_c && full_c && !log_clear) begin
        log_overflow <= 1'b1;
      end else if (log_clear) begin
        log_overflow <= 1'b0;
      end
    end
  end

  assign log_count = count_q;
  assign log_full = full_c;

  // ----------------------------------------------------------------
  // host readout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_miss <= 1'b0;
      rd_code <= RST_WORD;
      rd_detail <= RST_WORD;
      rd_byte_hi <= RST_BYTE;
      rd_byte_lo <= RST_BYTE;
    end else if (ce) begin
      rd_valid <= rd_req;
      if (rd_req) begin
        if ({1'b0, rd_idx} < count_q) begin
          rd_miss <= 1'b0;
          rd_code <= code_mem[rd_idx]; // see RULE17
          rd_detail <= det_mem[rd_idx];
          rd_byte_hi <= det_mem[rd_idx][BYTE_HI_LSB +: 8]; // see RULE16
          rd_byte_lo <= det_mem[rd_idx][BYTE_LO_LSB +: 8]; // see RULE16
        end else begin
          rd_miss <= 1'b1;
          rd_code <= RST_WORD;
          rd_detail <= RST_WORD;
          rd_byte_hi <= RST_BYTE;
          rd_byte_lo <= RST_BYTE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // most recent entry
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      new_entry <= 1'b0;
      last_code <= RST_WORD;
      last_detail <= RST_WORD;
    end else if (ce) begin
      new_entry <= wr_c;
      if (wr_c) begin
        last_code <= code_c;
        last_detail <= detail_c;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-cause hit counters
  // ----------------------------------------------------------------
  // counters saturate rather than wrap so a busy cause never reads as quiet;
  // they count dropped entries too and are reset by the log clear
  logic [HIT_W-1:0] hit_q [NUM_CAUSES];

  for (genvar g = 0; g < NUM_CAUSES; g++) begin : g_hit
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        hit_q[g] <= '0;
      end else if (ce) begin
        if (ev_c && fail_cause == 4'(g)) begin
          if (log_clear) begin
            hit_q[g] <= HIT_W'(1);
          end else if (hit_q[g] != '1) begin
            hit_q[g] <= hit_q[g] + HIT_W'(1);
          end
        end else if (log_clear) begin
          hit_q[g] <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hit_value <= '0;
    end else if (ce) begin
      hit_value <= (hit_sel < 4'(NUM_CAUSES)) ? hit_q[hit_sel] : '0;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile write
  // ----------------------------------------------------------------
  // one write in flight; a second controller fault during it is not queued,
  // the slow store would otherwise need a buffer of its own
  lle_nv_e nv_q;
  logic nv_start_c;

  assign nv_start_c = ev_c && to_nv_c; // see RULE2

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nv_q <= NV_IDLE;
    end else if (ce) begin
      unique case (nv_q)
        NV_IDLE: if (nv_start_c) nv_q <= NV_REQ;
        NV_REQ: if (nv_ack) nv_q <= NV_DONE;
        NV_DONE: nv_q <= NV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nv_code <= RST_WORD;
      nv_detail <= RST_WORD;
    end else if (ce && nv_start_c && nv_q == NV_IDLE) begin
      nv_code <= code_c;
      nv_detail <= detail_c;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nv_lost <= 1'b0;
    end else if (ce) begin
      if (nv_start_c && nv_q != NV_IDLE) begin
        nv_lost <= 1'b1;
      end else if (log_clear) begin
        nv_lost <= 1'b0;
      end
    end
  end

  assign nv_req = (nv_q == NV_REQ);
  assign nv_busy = (nv_q != NV_IDLE);

endmodule // lle_link_error_log_encoder

// ===== tb/lle_monitor.sv
// concurrent checks on the link error log encoder ports
`timescale 1ns/1ns
module lle_monitor
  import lle_pkg::*;
#(
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic fail_valid,
  input wire logic [3:0] fail_cause,
  input wire logic fail_is_resp,
  input wire logic [7:0] fail_node,
  input wire logic [6:0] fail_net,
  input wire logic tx_abort,
  input wire logic pkt_reject,
  input wire logic log_clear,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [15:0] rd_detail,
  input wire logic [7:0] rd_byte_hi,
  input wire logic [7:0] rd_byte_lo,
  input wire logic [AW:0] log_count,
  input wire logic log_full,
  input wire logic new_entry,
  input wire logic [15:0] last_code,
  input wire logic [15:0] last_detail,
  input wire logic nv_req,
  input wire logic [15:0] nv_code,
  input wire logic nv_ack,
  input wire logic nv_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_stored;
    ce && fail_valid && fail_cause < 4'hE && !log_full;
  endsequence
  sequence s_ack_done;
    !nv_req && nv_busy ##1 !nv_busy;
  endsequence
  code_map_a: assert property (s_stored |=> new_entry &&
    last_code == CODE_DEST_BUSY + 16'($past(fail_cause))) else $error("wrong code");
  detail_fmt_a: assert property (s_stored |=>
    last_detail == {$past(fail_is_resp), $past(fail_net), $past(fail_node)})
    else $error("wrong detail");
  byte_split_a: assert property (rd_valid |->
    {rd_byte_hi, rd_byte_lo} == rd_detail) else $error("byte split wrong");
  abort_map_a: assert property (ce |-> ##1 tx_abort ==
    $past(fail_valid && fail_cause inside {[4'h4:4'h7]})) else $error("abort wrong");
  reject_map_a: assert property (ce |-> ##1 pkt_reject ==
    $past(fail_valid && fail_cause inside {4'h8, 4'h9})) else $error("reject wrong");
  nv_start_a: assert property (ce && fail_valid && fail_cause == 4'h1 && !nv_busy
    |=> nv_req && nv_code == CODE_CTRL_FAULT) else $error("nv write missing");
  nv_only_a: assert property (nv_req |-> nv_code == CODE_CTRL_FAULT)
    else $error("volatile code stored");
  nv_done_a: assert property (ce && nv_req && nv_ack |=> s_ack_done)
    else $error("nv handshake wrong");
  count_up_a: assert property (s_stored ##0 !log_clear |=>
    log_count == $past(log_count) + 1'b1) else $error("count wrong");
  read_lat_a: assert property (ce && rd_req |=> rd_valid) else $error("no read answer");
endmodule // lle_monitor

bind lle_link_error_log_encoder lle_monitor #(.AW(AW)) i_lle_monitor (.*);

// ===== tb/lle_nv_model.sv
// nonvolatile store model answering the encoder's write handshake
`timescale 1ns/1ns
module lle_nv_model (
  // handshake
  input wire logic clk_sys,
  input wire logic nv_req,
  input wire logic [15:0] nv_code,
  input wire logic [15:0] nv_detail,
  output logic nv_ack,
  // test control and record
  input wire logic [3:0] ack_dly,
  output logic [31:0] saved,
  output logic [7:0] saves
);
  logic [3:0] cnt;
  initial begin
    nv_ack = 1'b0;
    cnt = 4'h0;
    saved = 32'h0;
    saves = 8'h0;
  end
  // ack held until the request drops, so slow answers still meet the handshake
  always @(negedge clk_sys) begin
    if (!nv_req) begin
      cnt <= 4'h0;
      nv_ack <= 1'b0;
    end else if (cnt >= ack_dly && !nv_ack) begin
      nv_ack <= 1'b1;
      saved <= {nv_code, nv_detail};
      saves <= saves + 8'h1;
    end else if (!nv_ack) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // lle_nv_model

// ===== tb/lle_link_error_log_encoder_tb_top.sv
// self-checking testbench for the link error log encoder
`timescale 1ns/1ns
module lle_link_error_log_encoder_tb_top;
  import lle_pkg::*;
  logic clk_sys, nrst, ce, fail_valid, fail_is_resp, log_clear, rd_req, nv_ack;
  logic tx_abort, pkt_reject, bad_cause, rd_valid, rd_miss, log_full, log_overflow;
  logic new_entry, nv_req, nv_busy, nv_lost;
  logic [3:0] fail_cause, rd_idx, hit_sel, ack_dly;
  logic [7:0] fail_node, rd_byte_hi, rd_byte_lo, hit_value, saves;
  logic [6:0] fail_net;
  logic [15:0] rd_code, rd_detail, last_code, last_detail, nv_code, nv_detail;
  logic [4:0] log_count;
  logic [31:0] saved;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  lle_link_error_log_encoder i_lle_link_error_log_encoder (.clk_sys(clk_sys), .nrst(nrst),
    .ce(ce), .fail_valid(fail_valid), .fail_cause(fail_cause), .fail_is_resp(fail_is_resp),
    .fail_node(fail_node), .fail_net(fail_net), .tx_abort(tx_abort), .pkt_reject(pkt_reject),
    .bad_cause(bad_cause), .log_clear(log_clear), .rd_req(rd_req), .rd_idx(rd_idx),
    .rd_valid(rd_valid), .rd_miss(rd_miss), .rd_code(rd_code), .rd_detail(rd_detail),
    .rd_byte_hi(rd_byte_hi), .rd_byte_lo(rd_byte_lo), .log_count(log_count),
    .log_full(log_full), .log_overflow(log_overflow), .new_entry(new_entry),
    .last_code(last_code), .last_detail(last_detail), .hit_sel(hit_sel),
    .hit_value(hit_value), .nv_req(nv_req), .nv_code(nv_code), .nv_detail(nv_detail),
    .nv_ack(nv_ack), .nv_busy(nv_busy), .nv_lost(nv_lost));
  lle_nv_model i_lle_nv_model (.clk_sys(clk_sys), .nv_req(nv_req), .nv_code(nv_code),
    .nv_detail(nv_detail), .nv_ack(nv_ack), .ack_dly(ack_dly), .saved(saved), .saves(saves));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one failure report; returns in the cycle its answer stands
  task automatic send(input logic [3:0] c, input logic [7:0] nd, input logic [6:0] nt,
                      input logic rs);
    @(negedge clk_sys);
    fail_valid = 1'b1;
    fail_cause = c;
    fail_node = nd;
    fail_net = nt;
    fail_is_resp = rs;
    @(negedge clk_sys);
    fail_valid = 1'b0;
  endtask

  task automatic rd(input logic [3:0] i);
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_idx = i;
    @(negedge clk_sys);
    rd_req = 1'b0;
    chk(rd_valid, 1'b1);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 14; c++) begin
      send(4'(c), 8'(c * 17 + 1), 7'(c + 100), c[0]);
      chk(new_entry, 1'b1);
      chk(last_code, 16'h0109 + 16'(c));
      chk(last_detail, {c[0], 7'(c + 100), 8'(c * 17 + 1)});
      chk(tx_abort, c >= 4 && c <= 7);
      chk(pkt_reject, c == 8 || c == 9);
    end
    for (int i = 0; i < 14; i++) begin
      rd(4'(i));
      chk(rd_code, 16'h0109 + 16'(i));
      chk(rd_detail, {i[0], 7'(i + 100), 8'(i * 17 + 1)});
      chk({rd_byte_hi, rd_byte_lo}, {i[0], 7'(i + 100), 8'(i * 17 + 1)});
    end
    hit_sel = 4'h1;
    @(negedge clk_sys);
    chk(hit_value, 8'h01);
    chk(saves, 8'h01);
  endtask

  task automatic t_full();
    send(4'hD, 8'hFF, 7'h7F, 1'b1);
    send(4'h0, 8'h00, 7'h00, 1'b0);
    chk(log_full, 1'b1);
    send(4'h3, 8'h01, 7'h01, 1'b0);
    chk(new_entry, 1'b0);
    chk({log_overflow, log_count}, 6'h30);
    send(4'hE, 8'h01, 7'h01, 1'b0);
    chk({bad_cause, new_entry}, 2'b10);
    // the dropped unit-number report still counts against its cause
    hit_sel = 4'h3;
    @(negedge clk_sys);
    chk(hit_value, 8'h02);
  endtask

  task automatic t_clear();
    @(negedge clk_sys);
    log_clear = 1'b1;
    @(negedge clk_sys);
    log_clear = 1'b0;
    chk({log_overflow, log_count}, 6'h00);
    rd(4'h0);
    chk({rd_miss, rd_code}, 17'h10000);
    chk(hit_value, 8'h00);
  endtask

  // slow store: a second controller fault meets a busy handshake
  task automatic t_nv();
    ack_dly = 4'h6;
    send(4'h1, 8'hA5, 7'h5A, 1'b1);
    send(4'h1, 8'h11, 7'h22, 1'b0);
    chk(nv_lost, 1'b1);
    for (int n = 0; n < 30 && nv_busy; n++) @(negedge clk_sys);
    chk(saves, 8'h02);
    chk(saved, {CODE_CTRL_FAULT, 16'hDAA5});
  endtask

  // clock enable low: a report on a frozen edge leaves no trace
  task automatic t_freeze();
    @(negedge clk_sys);
    ce = 1'b0;
    send(4'h5, 8'h33, 7'h44, 1'b0);
    chk({tx_abort, new_entry, log_count}, 7'h02);
    ce = 1'b1;
    send(4'h5, 8'h33, 7'h44, 1'b0);
    chk({tx_abort, new_entry, log_count}, 7'h63);
    chk(last_code, CODE_NO_ROUTE);
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    fail_valid = 1'b0;
    fail_cause = 4'h0;
    fail_is_resp = 1'b0;
    fail_node = 8'h00;
    fail_net = 7'h00;
    log_clear = 1'b0;
    rd_req = 1'b0;
    rd_idx = 4'h0;
    hit_sel = 4'h0;
    ack_dly = 4'h0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    t_codes();
    t_full();
    t_clear();
    t_nv();
    t_freeze();
    print_verdict();
  end

  // hang guard, far above the hundred or so cycles the scenarios need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
endmodule // lle_link_error_log_encoder_tb_top
